// ==== src/srh_host.sv ====
// Host controller that drives a 256 x 4 asynchronous static RAM through its pins.
// Assumes the memory pins are sampled synchronously and the timer shapes phases.
`timescale 1ns/1ps
`include "srh_cfg.svh"
module srh_host #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 4,
    parameter int SHARED_BUS = 1
) (
    // Clock and reset.
    input  wire logic                core_clk,
    input  wire logic                rstn,
    // User request side.
    input  wire logic                reqValid,
    input  wire logic                reqWrite,
    input  wire logic [ADDR_W-1:0]   reqAddr,
    input  wire logic [DATA_W-1:0]   reqData,
    input  wire logic                retainReq,
    output logic                     reqReady,
    output logic                     rspValid,
    output logic [DATA_W-1:0]        rspData,
    // Memory pins.
    output logic                     select_active_low,
    output logic                     select_active_high,
    output logic                     readWrite,
    output logic [ADDR_W-1:0]        word_address,
    output logic [DATA_W-1:0]        write_data_in,
    output logic                     dataOe,
    output logic                     output_float_control,
    input  wire logic [DATA_W-1:0]   read_data_out
);
    import srh_pkg::*;

    localparam srh_cnt_t SETUP_CYC = srh_cnt_t'(`SRH_CEIL(`SRH_ADDR_SETUP_NS));
    localparam srh_cnt_t PULSE_CYC = srh_cnt_t'(`SRH_CEIL(`SRH_WRITE_PULSE_NS));
    localparam srh_cnt_t ACC_CYC   = srh_cnt_t'(`SRH_CEIL(`SRH_ACCESS_NS));
    localparam srh_cnt_t RECOV_CYC = srh_cnt_t'(`SRH_CEIL(`SRH_WRITE_RECOV_NS));
    localparam srh_cnt_t DESEL_CYC = srh_cnt_t'(`SRH_CEIL(`SRH_READ_CYCLE_NS));

    srh_state_e state;
    logic       curWrite;
    logic       timerLoad;
    srh_cnt_t   timerValue;
    logic       timerDone;

    srh_timer #(
        .CNT_W(`SRH_CNT_W)
    ) u_timer (
        .core_clk (core_clk),
        .rstn     (rstn),
        .load     (timerLoad),
        .loadValue(timerValue),
        .done     (timerDone)
    );

    // Phase sequencer; each timed phase (setup, strobe, hold, recover) loads the timer once on entry.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state      <= SRH_RECOVER;
            timerLoad  <= 1'b1;
            timerValue <= DESEL_CYC;
            curWrite   <= 1'b0;
        end else begin
            timerLoad <= 1'b0;
            unique case (state)
                SRH_IDLE: begin
                    if (retainReq) begin
                        state <= SRH_RETAIN;
                    end else if (reqValid) begin
                        state      <= SRH_SETUP;
                        curWrite   <= reqWrite;
                        timerLoad  <= 1'b1;
                        timerValue <= SETUP_CYC;
                    end
                end
                SRH_SETUP: begin
                    if (timerDone && !timerLoad) begin
                        state      <= SRH_STROBE;
                        timerLoad  <= 1'b1;
                        timerValue <= curWrite ? PULSE_CYC : ACC_CYC;
                    end
                end
                SRH_STROBE: begin
                    if (timerDone && !timerLoad) begin
                        state      <= SRH_HOLD;
                        timerLoad  <= 1'b1;
                        timerValue <= RECOV_CYC;
                    end
                end
                SRH_HOLD: begin
                    if (timerDone && !timerLoad) begin
                        state <= SRH_IDLE;
                    end
                end
                SRH_RETAIN: begin
                    // Supply may have dropped; the deselect hold runs after release.
                    if (!retainReq) begin
                        state      <= SRH_RECOVER;
                        timerLoad  <= 1'b1;
                        timerValue <= DESEL_CYC; // R10
                    end
                end
                SRH_RECOVER: begin
                    if (timerDone && !timerLoad) begin
                        state <= SRH_IDLE; // R10
                    end
                end
            endcase
        end
    end

    // Selects: low select active only in setup, strobe and hold; high select low in retention and recovery.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            select_active_low  <= 1'b1;
            select_active_high <= 1'b0;
        end else begin
            select_active_low  <= !(state == SRH_SETUP || state == SRH_STROBE
                                   || state == SRH_HOLD); // R1 R2
            select_active_high <= (state != SRH_RETAIN) && (state != SRH_RECOVER); // R3 R10
        end
    end

    // Address and write data are latched on acceptance and held steady for standby.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            word_address  <= '0;
            write_data_in <= '0;
        end else if (state == SRH_IDLE && reqValid && !retainReq) begin
            word_address  <= reqAddr; // R9
            write_data_in <= reqData; // R11
        end
    end

    // Read/write drops only during the write strobe, inside the selected window.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            readWrite <= 1'b1;
        end else begin
            readWrite <= !(state == SRH_STROBE && curWrite); // R4 R11
        end
    end

    // Output disable on a shared bus low only during read cycles, high otherwise; with separate wiring high in reset, low from then on.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            output_float_control <= 1'b1;
            dataOe               <= 1'b0;
        end else begin
            if (SHARED_BUS != 0) begin
                output_float_control <= !(state != SRH_IDLE && !curWrite
                                         && state != SRH_RETAIN
                                         && state != SRH_RECOVER); // R7 R12 R6
            end else begin
                output_float_control <= 1'b0; // R8
            end
            dataOe <= (state == SRH_SETUP || state == SRH_STROBE || state == SRH_HOLD)
                      && curWrite; // R6
        end
    end

    // Read data is captured at the end of access time, unmodified.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rspValid <= 1'b0;
            rspData  <= '0;
        end else begin
            rspValid <= 1'b0;
            if (state == SRH_STROBE && !curWrite && timerDone && !timerLoad) begin
                rspValid <= 1'b1;
                rspData  <= read_data_out; // R5
            end
        end
    end

    // Ready is a registered view of the idle state with no request or retention pending.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reqReady <= 1'b0;
        end else begin
            reqReady <= (state == SRH_IDLE) && !reqValid && !retainReq;
        end
    end

    // Selected only within an access window.
    select_window_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !select_active_low |-> select_active_high) // R1
        else $error("low select active while high select low");

    write_od_high_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (SHARED_BUS != 0 && !readWrite) |-> output_float_control) // R7
        else $error("output disable low during write on shared bus");

    write_inside_sel_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !readWrite |-> !select_active_low && dataOe) // R11
        else $error("write strobe outside select or without data drive");

    retain_low_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (state == SRH_RETAIN) |=> !select_active_high) // R10
        else $error("high select not low in retention");

    recover_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (state == SRH_RECOVER) |=> !select_active_high && select_active_low) // R10
        else $error("memory selected during deselect hold");

    // Address and data may move only while deselected, never inside an access.
    standby_steady_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !select_active_low |-> $stable(word_address) && $stable(write_data_in)) // R2
        else $error("address or data moved while selected");

    read_capture_a: assert property (@(posedge core_clk) disable iff (!rstn)
        rspValid |-> $past(state) == SRH_STROBE && !curWrite) // R4
        else $error("read response outside read strobe");

    bus_contend_a: assert property (@(posedge core_clk) disable iff (!rstn)
        dataOe && SHARED_BUS != 0 |-> output_float_control) // R12
        else $error("host drives bus while memory outputs enabled");
endmodule

// ==== src/srh_cfg.svh ====
// Constants for the static RAM host controller.
// Assumes a 100 MHz core clock and a 256 x 4 asynchronous memory outside.
// Overview of operation
// (R1) Memory is selected only while low select is low and high select is high.
// (R2) Standby: drive low select high and keep address and controls steady.
// (R3) Driving high select low forces unconditional standby on the memory.
// (R4) With read/write high while selected, the memory presents the addressed word.
// (R5) Read data equals written data with no inversion; reads are non-destructive.
// (R6) Separate data pins; a shared bus floats outputs with the output disable.
// (R7) On a shared bus the host holds the output disable high during writes.
// (R8) With separate wiring the host may keep the output disable low always.
// (R9) The array holds 256 words of 4 bits addressed by 8 bits.
// (R10) Retention: high select low; after power returns deselect one read cycle.
// (R11) Selected with read/write low, the memory stores the input data word.
// (R12) Outputs float when deselected, in standby or with output disable high.
`ifndef SRH_CFG_SVH
`define SRH_CFG_SVH
`define SRH_CLK_PERIOD_NS 10
`define SRH_READ_CYCLE_NS 800
`define SRH_WRITE_CYCLE_NS 800
`define SRH_ADDR_SETUP_NS 200
`define SRH_WRITE_PULSE_NS 400
`define SRH_WRITE_RECOV_NS 50
`define SRH_ACCESS_NS 800
`define SRH_CEIL(t) (((t) + `SRH_CLK_PERIOD_NS - 1) / `SRH_CLK_PERIOD_NS)
`define SRH_CNT_W 8
`endif

// ==== src/srh_pkg.sv ====
// Types for the static RAM host controller.
// Assumes the constants header is included by users of timing values.
package srh_pkg;
    typedef enum logic [2:0] {
        SRH_IDLE,
        SRH_RECOVER,
        SRH_SETUP,
        SRH_STROBE,
        SRH_HOLD,
        SRH_RETAIN
    } srh_state_e;
    typedef logic [7:0] srh_cnt_t;
endpackage

// ==== src/srh_timer.sv ====
// Down counter that times the phases of a memory cycle.
// Assumes load and start values are sampled on the core clock.
`timescale 1ns/1ps
module srh_timer #(
    parameter int CNT_W = 8
) (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             rstn,
    // Load request and value.
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] loadValue,
    // Expiry level.
    output logic                  done
);
    logic [CNT_W-1:0] count;

    // The count saturates at zero so done stays high until a new load.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else if (load) begin
            count <= loadValue;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    // Done is registered alongside the count so it rises in the same cycle the count reaches zero.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            done <= 1'b0;
        end else begin
            done <= !load && (count <= {{(CNT_W-1){1'b0}}, 1'b1});
        end
    end
endmodule

// ==== bench/srh_mem_model.sv ====
// Behavioural 256 x 4 static memory that answers the host controller's pins.
// Assumes the host drives every pin and the core clock paces the fault monitor.
`timescale 1ns/1ps
module srh_mem_model (
    // Monitor clock.
    input  wire logic       core_clk,
    // Memory pins.
    input  wire logic       select_active_low,
    input  wire logic       select_active_high,
    input  wire logic       readWrite,
    input  wire logic [7:0] word_address,
    input  wire logic [3:0] write_data_in,
    input  wire logic       dataOe,
    input  wire logic       output_float_control,
    output logic [3:0]      read_data_out,
    // Sticky flag for host misbehaviour.
    output logic            fault
);
    logic [3:0] store [256];
    logic [3:0] lastOut = 4'h0;
    logic       chosen;
    logic       driving;
    initial fault = 1'b0;
    // Selected only with both selects active; a low high-select always wins.
    assign chosen  = !select_active_low && select_active_high;
    assign driving = chosen && readWrite && !output_float_control;
    // A word lands as the write pulse ends, so mid-pulse data is never kept.
    always @(posedge readWrite) begin
        if (chosen) store[word_address] <= write_data_in;
    end
    // Floated outputs toggle every cycle so a stale word cannot pass for a read.
    always @* begin
        read_data_out = driving ? store[word_address] : ~lastOut;
    end
    // Flags a clash on the shared bus or a write with outputs still enabled.
    always @(posedge core_clk) begin
        lastOut <= read_data_out;
        if ((dataOe && driving) || (chosen && !readWrite && !output_float_control)) begin
            fault <= 1'b1;
        end
    end
endmodule

// ==== bench/srh_host_test.sv ====
// Self-checking bench for the static RAM host controller.
// Assumes the memory model stands on the pins and a 100 MHz core clock.
`timescale 1ns/1ps
module srh_host_test;
    logic       core_clk  = 1'b0;
    logic       rstn      = 1'b0;
    logic       reqValid  = 1'b0;
    logic       reqWrite  = 1'b0;
    logic [7:0] reqAddr   = 8'h00;
    logic [3:0] reqData   = 4'h0;
    logic       retainReq = 1'b0;
    logic       reqReady, rspValid, selLow, selHigh, readWrite, dataOe, odCtl, fault;
    logic       odSep;
    logic [3:0] rspData, wData, rData;
    logic [7:0] addr;
    int         errTotal  = 0;
    int         checked   = 0;

    // Core clock at 100 MHz.
    always #5 core_clk = ~core_clk;

    srh_host dut (
        .core_clk(core_clk), .rstn(rstn), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqData(reqData), .retainReq(retainReq), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .select_active_low(selLow),
        .select_active_high(selHigh), .readWrite(readWrite), .word_address(addr),
        .write_data_in(wData), .dataOe(dataOe), .output_float_control(odCtl),
        .read_data_out(rData)
    );
    srh_mem_model mem (
        .core_clk(core_clk), .select_active_low(selLow), .select_active_high(selHigh),
        .readWrite(readWrite), .word_address(addr), .write_data_in(wData),
        .dataOe(dataOe), .output_float_control(odCtl), .read_data_out(rData),
        .fault(fault)
    );
    // Separate wiring variant in lockstep; only its output disable is watched.
    srh_host #(
        .SHARED_BUS(0)
    ) dutSep (
        .core_clk(core_clk), .rstn(rstn), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqData(reqData), .retainReq(retainReq), .reqReady(),
        .rspValid(), .rspData(), .select_active_low(), .select_active_high(),
        .readWrite(), .word_address(), .write_data_in(), .dataOe(),
        .output_float_control(odSep), .read_data_out(rData)
    );

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Numbers of the pins that a bounded wait can watch.
    localparam int W_READY = 0;
    localparam int W_RW    = 1;
    localparam int W_RSP   = 2;
    localparam int W_SELHI = 3;
    localparam int W_SELLO = 4;

    // Picks the watched pin by number, so the wait needs no reference argument.
    function automatic logic pick(input int which);
        case (which)
            W_READY: return reqReady;
            W_RW:    return readWrite;
            W_RSP:   return rspValid;
            W_SELHI: return selHigh;
            default: return selLow;
        endcase
    endfunction

    // Bounded wait so a stuck handshake ends as a mismatch, not a hang.
    task automatic wait_level(input int which, input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pick(which) !== lvl && n < 500);
        if (n >= 500) chk("handshake", 8'h00, 8'h01);
    endtask

    task automatic access(input logic w, input logic [7:0] a, input logic [3:0] d,
                          output logic [3:0] rd);
        int n;
        wait_level(W_READY, 1'b1, n);
        reqWrite <= w;
        reqAddr  <= a;
        reqData  <= d;
        reqValid <= 1'b1;
        if (w) begin
            wait_level(W_RW, 1'b0, n);
            chk("float_in_write", 8'h01, {7'h00, odCtl});
            chk("float_separate", 8'h00, {7'h00, odSep});
            chk("data_drive", 8'h01, {7'h00, dataOe});
            wait_level(W_RW, 1'b1, n);
        end else begin
            wait_level(W_RSP, 1'b1, n);
        end
        rd = rspData;
        reqValid <= 1'b0;
    endtask

    task automatic t_reset_recover;
        int n;
        chk("low_select_reset", 8'h01, {7'h00, selLow});
        chk("high_select_reset", 8'h00, {7'h00, selHigh});
        rstn <= 1'b1;
        wait_level(W_READY, 1'b1, n);
        chk("recovery_long", 8'h01, {7'h00, n >= 80});
    endtask

    task automatic t_write_read;
        logic [7:0] at [4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5};
        logic [3:0] got;
        for (int i = 0; i < 4; i++) access(1'b1, at[i], ~at[i][3:0], got);
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 4; i++) begin
                access(1'b0, at[i], 4'h0, got);
                chk("read_word", {4'h0, ~at[i][3:0]}, {4'h0, got});
            end
        end
    endtask

    task automatic t_retain;
        int n;
        retainReq <= 1'b1;
        wait_level(W_SELHI, 1'b0, n);
        chk("retain_entry", 8'h01, {7'h00, n < 20});
        repeat (20) @(posedge core_clk);
        chk("retain_hold", 8'h00, {7'h00, selHigh});
        retainReq <= 1'b0;
        reqWrite  <= 1'b0;
        reqAddr   <= 8'h5A;
        reqValid  <= 1'b1;
        wait_level(W_SELLO, 1'b0, n);
        chk("retain_exit", 8'h01, {7'h00, n >= 80});
        wait_level(W_RSP, 1'b1, n);
        chk("retained_word", 8'h05, {4'h0, rspData});
        reqValid <= 1'b0;
    endtask

    task automatic report_and_stop;
        if (errTotal == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence: reset held four cycles, then each scenario in turn.
    initial begin
        repeat (4) @(posedge core_clk);
        t_reset_recover();
        t_write_read();
        t_retain();
        chk("bus_fault", 8'h00, {7'h00, fault});
        report_and_stop();
    end

    // Watchdog well beyond the roughly 1500 cycles the scenarios need.
    initial begin
        #100us;
        errTotal++;
        report_and_stop();
    end
endmodule
